// File: rtl/cir_pkg.sv
/*
 * Constants for the card information register set: field values,
 * command codes, cell masks, power-up timing and the state type.
 * Assumes nothing of its surroundings; used as cir_pkg::name.
 */
package cir_pkg;

	// ----------------------------------------
	// Clock and power-up timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned PWRUP_TIME_US = 1000;
	localparam int unsigned PWRUP_CYCLES = PWRUP_TIME_US * CLK_MHZ;

	// ----------------------------------------
	// Commands
	// ----------------------------------------
	localparam logic [5:0] CMD_OP_COND = 6'h01;
	localparam logic [5:0] CMD_ALL_ID = 6'h02;
	localparam logic [5:0] CMD_SEND_CSD = 6'h09;
	localparam logic [5:0] CMD_SEND_ID = 6'h0a;
	localparam logic [5:0] CMD_PROG_CSD = 6'h1b;

	// ----------------------------------------
	// Supply conditions fields
	// ----------------------------------------
	localparam int unsigned SUP_READY_BIT = 31;
	localparam logic [8:0] SUP_HIGH_WIN = 9'h1ff;
	localparam logic [6:0] SUP_ZERO7 = 7'h00;

	// ----------------------------------------
	// Identity fields
	// ----------------------------------------
	localparam int unsigned ID_CRC_LSB = 1;
	localparam logic ID_TAIL = 1'b1;

	// ----------------------------------------
	// Specific-data fixed part, bits 127:16
	// ----------------------------------------
	localparam logic [1:0] CSD_LAYOUT = 2'h2;
	localparam logic [3:0] CSD_SPEC = 4'h4;
	localparam logic [7:0] CSD_ASYNC_ACC = 8'h26;
	localparam logic [7:0] CSD_CLK_ACC = 8'h01;
	localparam logic [7:0] CSD_SPEED = 8'h2a;
	localparam logic [11:0] CSD_CLASSES = 12'h0f5;
	localparam logic [3:0] CSD_BLK_LEN = 4'h9;
	localparam logic [11:0] CSD_SIZE = 12'h7ff;
	localparam logic [2:0] CSD_CURR_MIN = 3'h6;
	localparam logic [2:0] CSD_CURR_MAX = 3'h6;
	localparam logic [2:0] CSD_SIZE_MULT = 3'h7;
	localparam logic [4:0] CSD_ERASE_SIZE = 5'h1f;
	localparam logic [4:0] CSD_ERASE_MULT = 5'h1f;
	localparam logic [4:0] CSD_PROT_SIZE = 5'h1f;
	localparam logic [2:0] CSD_SPEED_FACT = 3'h2;
	localparam logic [111:0] CSD_FIXED = {
		CSD_LAYOUT, CSD_SPEC, 2'h0, CSD_ASYNC_ACC, CSD_CLK_ACC,
		CSD_SPEED, CSD_CLASSES, CSD_BLK_LEN, 4'h0, 2'h0, CSD_SIZE,
		CSD_CURR_MIN, CSD_CURR_MAX, CSD_CURR_MIN, CSD_CURR_MAX,
		CSD_SIZE_MULT, CSD_ERASE_SIZE, CSD_ERASE_MULT, CSD_PROT_SIZE,
		1'b1, 2'h0, CSD_SPEED_FACT, CSD_BLK_LEN, 1'b0, 4'h0, 1'b0};

	// ----------------------------------------
	// Programmable cells, bits 15:1
	// ----------------------------------------
	localparam logic [15:1] CELL_ONCE = 15'h7600;
	localparam logic [15:1] CELL_ERASE = 15'h09ff;
	localparam logic [15:1] CELL_RESET = 15'h0000;

	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_BUSY = 2'b01,
		ST_READY = 2'b10
	} cir_state_t;

endpackage : cir_pkg

// File: rtl/cir_crc7.sv
/*
 * CRC7 (x^7 + x^3 + 1) over a 120-bit word, most significant bit
 * first, zero start value. Purely combinational.
 */
`timescale 1ns/100ps
module cir_crc7 (
	input wire logic [119:0] data,
	output logic [6:0] crc
);
	logic [6:0] chain [0:120];

	assign chain[0] = 7'h00;

	genvar i;
	generate
		for (i = 0; i < 120; i++) begin : g_bit
			logic fb;
			assign fb = data[119 - i] ^ chain[i][6];
			assign chain[i + 1] = {chain[i][5:0], 1'b0} ^ {3'h0, fb, 2'h0, fb};
		end
	endgenerate

	assign crc = chain[120];
endmodule : cir_crc7

// File: rtl/cir_pwrup.sv
/*
 * Power-up routine timer: counts while run is high, then holds done.
 * Assumes the caller gates run with the clock enable.
 */
`timescale 1ns/100ps
module cir_pwrup #(
	parameter int unsigned CYCLES = cir_pkg::PWRUP_CYCLES
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic run,
	output logic done
);
	logic [31:0] count;
	logic last;

	assign last = (count == 32'(CYCLES - 1));

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 32'h0;
			done <= 1'b0;
		end else if (run && !done) begin
			count <= count + 32'h1;
			done <= last;
		end
	end
endmodule : cir_pwrup

// File: rtl/cir_regs.sv
/*
 * Card information register set: supply conditions, identity and
 * specific-data registers, answered per card command.
 * Assumes a command decoder in front and a nonvolatile store behind
 * that presents the programmed cells at reset and takes write-backs.
 */
// How it works
// - Supply-conditions register, 32 bits, always present.
// - Bit 31 low until power-up finishes.
// - Busy pulls shared line low, wired AND.
// - Bits 23:15 one, others zero, 7 dual-only.
// - 128-bit identity register read at identification.
// - Identity unique per card via parameters.
// - Bits 127:120 hold maker code.
// - Bits 119:104 hold owner code.
// - Bits 103:56 hold six-character product name.
// - Bits 55:48 hold BCD revision n.m.
// - Bits 47:16 hold binary serial number.
// - Bits 15:8 hold month and year.
// - Bits 7:1 CRC7, bit 0 one.
// - 128-bit specific-data register with fixed layout.
// - Only writable cells change, only by program command.
// - Once cells fixed after first write; erasable cells free.
// - Capabilities fields hold the fixed advertised values.
// - Fields are unsigned, leftmost bit most significant.
// - Layout code 2, specification code 4.
// - Access time unit low, multiplier above.
// - Block length code is power of two.
// - Transfer speed holds the 20 MHz code.
`timescale 1ns/100ps
module cir_regs #(
	parameter int unsigned PWRUP_CYCLES = cir_pkg::PWRUP_CYCLES,
	parameter logic DUAL_VOLT = 1'b0,
	// Arbitrary maker code, not an allocated value
	parameter logic [7:0] MAKER_CODE = 8'h5a,
	parameter logic [15:0] OWNER_CODE = 16'h4142,
	parameter logic [47:0] PRODUCT_NAME = 48'h434152443031,
	parameter logic [7:0] PRODUCT_REV = 8'h10,
	parameter logic [31:0] SERIAL_NUMBER = 32'h00000001,
	parameter logic [7:0] MAKE_DATE = 8'h10
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire logic [5:0] cmd_index,
	input wire logic [127:0] cmd_arg,
	input wire logic [15:1] nv_image,
	input wire logic nv_burned,
	output logic rsp_valid,
	output logic rsp_err,
	output logic [127:0] rsp_data,
	output logic rdy_oe,
	output logic nv_wr_valid,
	output logic [15:1] nv_wr_data
);
	// ----------------------------------------
	// State and storage
	// ----------------------------------------
	cir_pkg::cir_state_t state;
	cir_pkg::cir_state_t next_state;
	logic [15:1] cells;
	logic burned;
	logic pwr_done;

	// ----------------------------------------
	// Power-up timer
	// ----------------------------------------
	wire logic pwr_run = ce && (state == cir_pkg::ST_BUSY);

	cir_pwrup #(
		.CYCLES(PWRUP_CYCLES)
	) u_pwrup (
		.mclk(mclk),
		.arst_n(arst_n),
		.run(pwr_run),
		.done(pwr_done)
	);

	// ----------------------------------------
	// Register images
	// ----------------------------------------
	wire logic ready = (state == cir_pkg::ST_READY);

	wire logic [31:0] sup_img = {ready, cir_pkg::SUP_ZERO7,
		cir_pkg::SUP_HIGH_WIN, cir_pkg::SUP_ZERO7, DUAL_VOLT,
		cir_pkg::SUP_ZERO7};

	wire logic [119:0] id_body = {MAKER_CODE, OWNER_CODE,
		PRODUCT_NAME, PRODUCT_REV, SERIAL_NUMBER, MAKE_DATE};
	logic [6:0] id_crc;

	cir_crc7 u_crc (
		.data(id_body),
		.crc(id_crc)
	);

	wire logic [127:0] id_img = {id_body, id_crc, cir_pkg::ID_TAIL};

	wire logic [127:0] csd_img = {cir_pkg::CSD_FIXED, cells, 1'b1};

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	wire logic take = ce && cmd_valid;
	wire logic is_sup = (cmd_index == cir_pkg::CMD_OP_COND);
	wire logic is_id = (cmd_index == cir_pkg::CMD_ALL_ID) ||
		(cmd_index == cir_pkg::CMD_SEND_ID);
	wire logic is_csd = (cmd_index == cir_pkg::CMD_SEND_CSD);
	wire logic is_prog = (cmd_index == cir_pkg::CMD_PROG_CSD);
	wire logic ans_sup = take && is_sup && (state != cir_pkg::ST_LOAD);
	wire logic ans_id = take && is_id && ready;
	wire logic ans_csd = take && is_csd && ready;
	wire logic ans_prog = take && is_prog && ready;

	// ----------------------------------------
	// Program checks
	// ----------------------------------------
	wire logic [15:1] wr_cells = cmd_arg[15:1];

	wire logic ro_ok = (cmd_arg[127:16] == cir_pkg::CSD_FIXED) &&
		cmd_arg[0];

	// once cells locked after first write
	wire logic once_ok = !burned ||
		(((wr_cells ^ cells) & cir_pkg::CELL_ONCE) == 15'h0000);
	wire logic accept = ro_ok && once_ok;
	wire logic [15:1] wmask = cir_pkg::CELL_ONCE | cir_pkg::CELL_ERASE;
	wire logic [15:1] next_cells = (wr_cells & wmask) | (cells & ~wmask);

	// ----------------------------------------
	// Answer selection
	// ----------------------------------------
	wire logic any_ans = ans_sup || ans_id || ans_csd || ans_prog;
	wire logic [127:0] sel_data = ans_sup ? {96'h0, sup_img} :
		ans_id ? id_img :
		(ans_prog && accept) ? {cir_pkg::CSD_FIXED, next_cells, 1'b1} :
		csd_img;

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			cir_pkg::ST_LOAD: begin
				next_state = cir_pkg::ST_BUSY;
			end
			cir_pkg::ST_BUSY: begin
				if (pwr_done) begin
					next_state = cir_pkg::ST_READY;
				end
			end
			cir_pkg::ST_READY: begin
				next_state = cir_pkg::ST_READY;
			end
			default: begin
				next_state = cir_pkg::ST_LOAD;
			end
		endcase
	end

	// Cells are caught from the store after release, never under reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= cir_pkg::ST_LOAD;
		end else if (ce) begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cells <= cir_pkg::CELL_RESET;
			burned <= 1'b0;
		end else if (ce && state == cir_pkg::ST_LOAD) begin
			cells <= nv_image;
			burned <= nv_burned;
		end else if (ans_prog && accept) begin
			cells <= next_cells;
			burned <= 1'b1;
		end
	end

	// ----------------------------------------
	// Answers and pins
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid <= 1'b0;
			rsp_err <= 1'b0;
			rsp_data <= 128'h0;
		end else if (ce) begin
			rsp_valid <= any_ans;
			rsp_err <= ans_prog && !accept;
			if (any_ans) begin
				rsp_data <= sel_data;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			nv_wr_valid <= 1'b0;
			nv_wr_data <= cir_pkg::CELL_RESET;
		end else if (ce) begin
			nv_wr_valid <= ans_prog && accept;
			if (ans_prog && accept) begin
				nv_wr_data <= next_cells;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdy_oe <= 1'b1;
		end else if (ce) begin
			rdy_oe <= (next_state != cir_pkg::ST_READY);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_prog_req;
		ce && cmd_valid && is_prog && ready;
	endsequence

	sequence s_written;
		ce ##1 rsp_valid && !rsp_err && nv_wr_valid;
	endsequence

	AST_SUP_WINDOW: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ans_sup |=> rsp_valid && rsp_data[23:15] == 9'h1ff &&
			rsp_data[14:8] == 7'h00 && rsp_data[30:24] == 7'h00 &&
			rsp_data[6:0] == 7'h00 && rsp_data[7] == DUAL_VOLT)
		else $error("supply window bits wrong");

	AST_SUP_BUSY: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ans_sup |=> rsp_data[31] == $past(ready))
		else $error("power-up flag does not follow state");

	AST_WIRED_LOW: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!ready |-> rdy_oe)
		else $error("busy card released the shared line");

	AST_ID_FIELDS: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ans_id |=> rsp_data[127:120] == MAKER_CODE &&
			rsp_data[47:16] == SERIAL_NUMBER && rsp_data[0])
		else $error("identity fields wrong");

	AST_ID_CRC: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ans_id |=> rsp_data[7:1] == $past(id_crc))
		else $error("identity checksum wrong");

	AST_CSD_CODES: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ans_csd |=> rsp_data[127:126] == 2'h2 &&
			rsp_data[83:80] == 4'h9 && rsp_data[103:96] == 8'h2a &&
			rsp_data[119:112] == 8'h26)
		else $error("specific-data codes wrong");

	AST_RO_REFUSE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_prog_req and !ro_ok |=> rsp_err && !nv_wr_valid &&
			$stable(cells))
		else $error("read-only cell change not refused");

	AST_ONCE_LOCK: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_prog_req and burned and
			((wr_cells ^ cells) & 15'h7600) != 15'h0000 |=> rsp_err &&
			!nv_wr_valid && $stable(cells))
		else $error("write-once cell rewritten");

	AST_PROG_OK: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_prog_req and accept |-> s_written ##0 burned &&
			nv_wr_data == cells)
		else $error("accepted program not stored");

	sequence s_id_req;
		ce && cmd_valid && is_id && ready;
	endsequence

	AST_ID_TEXT: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_id_req |=> rsp_valid && rsp_data[119:104] == OWNER_CODE &&
			rsp_data[103:56] == PRODUCT_NAME && rsp_data[55:48] == PRODUCT_REV &&
			rsp_data[15:8] == MAKE_DATE)
		else $error("identity text fields wrong");

	AST_CSD_CAPS: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ans_csd |=> rsp_valid && rsp_data[95:84] == 12'h0f5 &&
			rsp_data[111:104] == 8'h01 && rsp_data[79:76] == 4'h0 &&
			rsp_data[73:62] == cir_pkg::CSD_SIZE && rsp_data[0])
		else $error("advertised capabilities wrong");

	AST_QUIET_BUSY: assert property (
		@(posedge mclk) disable iff (!arst_n)
		take && !is_sup && !ready |=> !rsp_valid)
		else $error("card answered before power-up finished");

	AST_ERASE_FREE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_prog_req and ro_ok and
			((wr_cells ^ cells) & 15'h7600) == 15'h0000 |=> !rsp_err &&
			cells == $past(wr_cells))
		else $error("erasable cell change refused");

	AST_ERR_PAIRED: assert property (
		@(posedge mclk) disable iff (!arst_n)
		rsp_err |-> rsp_valid && !nv_wr_valid)
		else $error("refusal without an answer");

	AST_READY_FREE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ready |-> !rdy_oe)
		else $error("ready card still holds the shared line low");
endmodule : cir_regs

// File: test/cir_host.sv
/*
 * Host model: drives card commands, resolves the shared busy line and
 * keeps the nonvolatile cell store behind the card.
 * Assumes the bench calls send and idle from its main sequence.
 */
`timescale 1ns/100ps
module cir_host (
	input wire logic mclk,
	input wire logic rdy_oe,
	input wire logic other_busy,
	input wire logic nv_wr_valid,
	input wire logic [15:1] nv_wr_data,
	output logic cmd_valid,
	output logic [5:0] cmd_index,
	output logic [127:0] cmd_arg,
	output logic [15:1] nv_image,
	output logic nv_burned,
	output logic line_high
);
	// ------------------------------
	// Shared busy line, pulled up
	// ------------------------------
	// wired AND line
	assign line_high = !(rdy_oe || other_busy);
	// ------------------------------
	// Cell store and command driver
	// ------------------------------
	initial begin
		cmd_valid = 1'b0;
		cmd_index = 6'h00;
		cmd_arg = 128'h0;
		nv_image = 15'h0000;
		nv_burned = 1'b0;
	end
	always @(posedge mclk) begin
		if (nv_wr_valid === 1'b1) begin
			nv_image <= nv_wr_data;
			nv_burned <= 1'b1;
		end
	end
	task automatic send(input logic [5:0] idx, input logic [127:0] arg);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_index <= idx;
		cmd_arg <= arg;
	endtask : send
	// Released lines change, so a stale value is never mistaken for a command
	task automatic idle();
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_index <= ~cmd_index;
		cmd_arg <= ~cmd_arg;
	endtask : idle
endmodule : cir_host

// File: test/cir_regs_tb_top.sv
/*
 * Self-checking bench for the card register set, driven by the host model.
 * Assumes a 50 MHz clock and a shortened power-up count.
 */
`timescale 1ns/100ps
module cir_regs_tb_top;
	localparam int unsigned PW = 8;
	// Arbitrary maker code
	localparam logic [7:0] MK = 8'ha7;
	localparam logic [15:0] OW = 16'h5a3c;
	localparam logic [47:0] NM = 48'h545354435244;
	localparam logic [7:0] RV = 8'h62;
	localparam logic [31:0] SN = 32'h80000001;
	localparam logic [7:0] DT = 8'h43;
	typedef struct {
		logic [5:0] idx;
		logic err;
		logic [127:0] data;
		logic wr;
	} cir_exp_t;
	cir_exp_t exp_q[$];
	cir_exp_t e;
	logic mclk, arst_n, ce, other_busy, cmd_valid, nv_burned, line_high;
	logic rsp_valid, rsp_err, rdy_oe, nv_wr_valid;
	logic [5:0] cmd_index;
	logic [127:0] cmd_arg, rsp_data, card_identity;
	logic [15:1] nv_image, nv_wr_data, cells;
	int bad_count, n_compared, seed, b;
	cir_regs #(.PWRUP_CYCLES(PW), .DUAL_VOLT(1'b1), .MAKER_CODE(MK), .OWNER_CODE(OW),
		.PRODUCT_NAME(NM), .PRODUCT_REV(RV), .SERIAL_NUMBER(SN), .MAKE_DATE(DT)) uut (
		.mclk(mclk), .arst_n(arst_n), .ce(ce), .cmd_valid(cmd_valid),
		.cmd_index(cmd_index), .cmd_arg(cmd_arg), .nv_image(nv_image),
		.nv_burned(nv_burned), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
		.rsp_data(rsp_data), .rdy_oe(rdy_oe), .nv_wr_valid(nv_wr_valid),
		.nv_wr_data(nv_wr_data));
	cir_host host (.mclk(mclk), .rdy_oe(rdy_oe), .other_busy(other_busy),
		.nv_wr_valid(nv_wr_valid), .nv_wr_data(nv_wr_data), .cmd_valid(cmd_valid),
		.cmd_index(cmd_index), .cmd_arg(cmd_arg), .nv_image(nv_image),
		.nv_burned(nv_burned), .line_high(line_high));
	// ------------------------------
	// Helpers
	// ------------------------------
	function automatic logic [6:0] crc7(input logic [119:0] d);
		logic [6:0] c;
		logic fb;
		c = 7'h00;
		for (int i = 119; i >= 0; i--) begin
			fb = d[i] ^ c[6];
			c = {c[5:0], 1'b0} ^ {3'h0, fb, 2'h0, fb};
		end
		return c;
	endfunction : crc7
	function automatic logic [127:0] card_specific_data(input logic [15:1] c);
		return {cir_pkg::CSD_FIXED, c, 1'b1};
	endfunction : card_specific_data
	function automatic logic [127:0] sup(input logic r);
		return {96'h0, r, 7'h00, 9'h1ff, 7'h00, 1'b1, 7'h00};
	endfunction : sup
	task automatic check(input logic [127:0] seen, input logic [127:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("Error at %0t: seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic cmd(input logic [5:0] idx, input logic [127:0] arg, input logic ans,
		input logic err, input logic [127:0] data, input logic wr);
		host.send(idx, arg);
		if (ans) exp_q.push_back('{idx, err, data, wr});
	endtask : cmd
	task automatic wait_ready();
		for (int i = 0; i < 40 && rdy_oe !== 1'b0; i++) @(posedge mclk);
		check(rdy_oe, 1'b0);
		@(posedge mclk);
	endtask : wait_ready
	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	// ------------------------------
	// Clock, monitor, watchdog
	// ------------------------------
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(negedge mclk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				bad_count++;
				$display("Error at %0t: unexpected answer", $time);
			end else begin
				e = exp_q.pop_front();
				check(rsp_data, e.data);
				check(rsp_err, e.err);
				check(nv_wr_valid, e.wr);
				if (e.wr) check(nv_wr_data, e.data[15:1]);
				if (e.idx == cir_pkg::CMD_SEND_CSD) begin
					check(rsp_data[127:126], 2'h2);
					check(rsp_data[103:96], 8'h2a);
					check(128'h1 << rsp_data[83:80], 128'h200);
					check(rsp_data[119:112], {1'b0, 4'h4, 3'h6});
				end
			end
		end
	end
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		seed = 18;
		bad_count = 0;
		n_compared = 0;
		arst_n = 1'b0;
		ce = 1'b1;
		other_busy = 1'b0;
		cells = 15'h0000;
		card_identity = {MK, OW, NM, RV, SN, DT, crc7({MK, OW, NM, RV, SN, DT}), 1'b1};
		repeat (12) @(posedge mclk);
		check(rdy_oe, 1'b1);
		arst_n <= 1'b1;
		// Not ready: identity ignored, supply says busy
		cmd(cir_pkg::CMD_SEND_ID, 128'h0, 1'b0, 1'b0, 128'h0, 1'b0);
		cmd(cir_pkg::CMD_OP_COND, 128'h0, 1'b1, 1'b0, sup(1'b0), 1'b0);
		host.idle();
		check(line_high, 1'b0);
		wait_ready();
		check(line_high, 1'b1);
		other_busy <= 1'b1;
		@(posedge mclk);
		check(line_high, 1'b0);
		other_busy <= 1'b0;
		// Back-to-back reads and an unknown code
		cmd(cir_pkg::CMD_OP_COND, 128'({$random(seed)}), 1'b1, 1'b0, sup(1'b1), 1'b0);
		cmd(cir_pkg::CMD_ALL_ID, 128'h0, 1'b1, 1'b0, card_identity, 1'b0);
		cmd(cir_pkg::CMD_SEND_ID, 128'h0, 1'b1, 1'b0, card_identity, 1'b0);
		cmd(cir_pkg::CMD_SEND_CSD, 128'h0, 1'b1, 1'b0, card_specific_data(cells), 1'b0);
		cmd(6'h3f, 128'h0, 1'b0, 1'b0, 128'h0, 1'b0);
		host.idle();
		// Freeze with no answer pending: a held pulse would read as a new one
		ce <= 1'b0;
		// Frozen clock enable: no answer
		cmd(cir_pkg::CMD_SEND_CSD, 128'h0, 1'b0, 1'b0, 128'h0, 1'b0);
		host.idle();
		ce <= 1'b1;
		// First program writes all cells and fixes the once cells
		cells = 15'($random(seed));
		cmd(cir_pkg::CMD_PROG_CSD, card_specific_data(cells), 1'b1, 1'b0, card_specific_data(cells), 1'b1);
		for (b = 1; b <= 15; b++) begin
			if (cir_pkg::CELL_ONCE[b]) begin
				cmd(cir_pkg::CMD_PROG_CSD, card_specific_data(cells ^ (15'h1 << (b - 1))), 1'b1, 1'b1,
					card_specific_data(cells), 1'b0);
			end else begin
				cells = cells ^ (15'h1 << (b - 1));
				cmd(cir_pkg::CMD_PROG_CSD, card_specific_data(cells), 1'b1, 1'b0, card_specific_data(cells), 1'b1);
			end
		end
		for (b = 0; b < 4; b++) begin
			cmd(cir_pkg::CMD_PROG_CSD, card_specific_data(cells) ^ (128'h10000 << ({$random(seed)} % 112)),
				1'b1, 1'b1, card_specific_data(cells), 1'b0);
		end
		cmd(cir_pkg::CMD_PROG_CSD, card_specific_data(cells) ^ 128'h1, 1'b1, 1'b1, card_specific_data(cells), 1'b0);
		cells = (cells & cir_pkg::CELL_ONCE) | (15'($random(seed)) & cir_pkg::CELL_ERASE);
		cmd(cir_pkg::CMD_PROG_CSD, card_specific_data(cells), 1'b1, 1'b0, card_specific_data(cells), 1'b1);
		host.idle();
		// Power cycle keeps programmed cells
		repeat (3) @(posedge mclk);
		arst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		check(rdy_oe, 1'b1);
		arst_n <= 1'b1;
		@(posedge mclk);
		wait_ready();
		cmd(cir_pkg::CMD_SEND_CSD, 128'h0, 1'b1, 1'b0, card_specific_data(cells), 1'b0);
		cmd(cir_pkg::CMD_PROG_CSD, card_specific_data(cells ^ 15'h4000), 1'b1, 1'b1, card_specific_data(cells), 1'b0);
		host.idle();
		repeat (5) @(posedge mclk);
		check(exp_q.size(), 128'h0);
		complete_run();
	end
endmodule : cir_regs_tb_top
